/* File: gain_cfg_pkg.sv */
// Purpose: Constants shared by the dual-gain serial configuration port.
// Assumes: The serial clock is far slower than sys_clk_i (400 ns against 50 ns).
// Notes: Latch upper nibble drives channel B, lower nibble channel A.
// Functional notes
// - Select low: shift input bit on rising clock.
// - Select rising edge copies shifter into latch.
// - Select high blocks serial clock; shifter holds.
// - First received bit is word MSB.
// - Output shows shifter MSB, updates falling edge.
// - Code 8 disables that channel only.
// - Hardware powerdown disables channels and port.
// - Floating powerdown input reads as low.
// - Reset or powerdown release loads code 8.
// - Each channel independently selects eight gains.
// - Upper nibble channel B, lower nibble A.
// - Serial output always actively driven.
package gain_cfg_pkg;
  localparam int WORD_W = 8;                     // Shift register and latch width.
  localparam int CODE_W = 4;                     // One channel code width.
  localparam int MSB_POS = 7;                    // Bit shown on the serial output.
  localparam int A_LO = 0;                       // Channel A field low bit.
  localparam int B_LO = 4;                       // Channel B field low bit.
  localparam logic [3:0] CODE_SW_OFF = 4'h8;     // Software shutdown code.
  localparam logic [7:0] LATCH_RESET = 8'h88;    // Both channels in software shutdown.
  localparam logic [7:0] SHIFT_RESET = 8'h00;    // Shifter value after reset.
  localparam int PIN_SEL = 0;                    // Select/load position in the pin bundle.
  localparam int PIN_CLK = 1;                    // Serial clock position in the pin bundle.
  localparam int PIN_DAT = 2;                    // Serial data position in the pin bundle.
  localparam int PIN_PD = 3;                     // Powerdown position in the pin bundle.
  localparam logic [3:0] PIN_IDLE = 4'h1;        // Idle pins: select high, the rest low.
endpackage : gain_cfg_pkg

/* File: gain_cfg_port.sv */
// Purpose: Serial configuration port feeding a two-channel gain latch.
// Assumes: Serial pins are asynchronous and are synchronised to sys_clk_i.
// Notes: Edges of the serial pins are found after a two-flop synchroniser.
//   A pin edge reaches the port logic three system clocks after the pin moves,
//   so the serial half period must span at least four system clocks.
//   The enable outputs stand in for the amplifiers, which are not modelled here.
`timescale 1ns/10ps
module gain_cfg_port
  import gain_cfg_pkg::*;
(
  input wire logic sys_clk_i,          // System clock, 20 MHz.
  input wire logic reset_i,            // Synchronous active-high reset.
  input wire logic select_load_n_i,    // Select/load pin, active low.
  input wire logic ser_clk_i,          // Serial clock pin from host.
  input wire logic ser_data_i,         // Serial data pin from host.
  input wire logic hw_powerdown_in_i,  // Hardware powerdown pin, active high.
  output logic ser_data_o,             // Daisy-chain serial output.
  output logic [7:0] gain_latch_o,     // Whole gain latch.
  output logic [3:0] gain_a_o,         // Channel A gain code.
  output logic [3:0] gain_b_o,         // Channel B gain code.
  output logic amp_a_en_o,             // Channel A amplifier enabled.
  output logic amp_b_en_o              // Channel B amplifier enabled.
);

  // Synchroniser stages; the first stage is read only by the second.
  logic [3:0] sync1_ff, nxt_sync1;
  logic [3:0] sync2_ff, nxt_sync2;
  logic [3:0] prev_ff, nxt_prev;       // Previous synced sample for edge finding.
  logic [WORD_W-1:0] shift_ff, nxt_shift;  // Serial shift register.
  logic [WORD_W-1:0] latch_ff, nxt_latch;  // Gain latch.
  logic dout_ff, nxt_dout;             // Serial output flop.
  logic [3:0] ga_ff, nxt_ga;           // Registered channel A code.
  logic [3:0] gb_ff, nxt_gb;           // Registered channel B code.
  logic ena_ff, nxt_ena;               // Registered channel A enable.
  logic enb_ff, nxt_enb;               // Registered channel B enable.

  // Synced pin levels, taken from the second synchroniser stage only.
  // Bundle positions are named in the package so the order is kept in one place.
  logic s_sel;                         // Synced select/load, high when idle.
  logic s_clk;                         // Synced serial clock.
  logic s_dat;                         // Synced serial data.
  logic s_pd;                          // Synced hardware powerdown.

  // Edge strobes, each high for one system clock.
  // Clock edges are qualified here, so the shifter never sees a blocked edge.
  logic clk_rise;                      // Serial clock rose with the port open.
  logic clk_fall;                      // Serial clock fell with the port open.
  logic sel_rise;                      // Select/load rose outside powerdown.
  logic pd_fall;                       // Powerdown was just released.

  // True when a channel code leaves the amplifier running.
  function automatic logic code_enabled(input logic [3:0] code);
    code_enabled = (code < CODE_SW_OFF);  // Codes 8 and above shut the channel down.
  endfunction : code_enabled

  // Picks one channel code out of a latch word; both channels share it.
  function automatic logic [CODE_W-1:0] chan_code(input logic [WORD_W-1:0] word, input int lo);
    chan_code = word[lo +: CODE_W];
  endfunction : chan_code

  // Input synchroniser next values.
  always_comb begin
    nxt_sync1 = {hw_powerdown_in_i, ser_data_i, ser_clk_i, select_load_n_i};
    nxt_sync2 = sync1_ff;
    nxt_prev = sync2_ff;
  end

  // Input synchroniser registers. Reset leaves powerdown low, as the pull-down would.
  // The reset pattern matches the idle pins, so no false edge follows reset.
  // A floating powerdown pin is pulled low outside; here it simply reads low.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      // Every stage starts at the idle pattern.
      sync1_ff <= PIN_IDLE;
      sync2_ff <= PIN_IDLE;
      prev_ff <= PIN_IDLE;
    end else begin
      // Pins move one stage along per clock.
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
    end
  end

  // Split the second stage back into named pins.
  assign s_sel = sync2_ff[PIN_SEL];
  assign s_clk = sync2_ff[PIN_CLK];
  assign s_dat = sync2_ff[PIN_DAT];
  assign s_pd = sync2_ff[PIN_PD];
  // The clock only counts while select is low and powerdown is low.
  // Data and clock share one synchroniser bank, so data keeps its setup to the clock.
  assign clk_rise = s_clk && !prev_ff[PIN_CLK] && !s_sel && !s_pd;
  assign clk_fall = !s_clk && prev_ff[PIN_CLK] && !s_sel && !s_pd;
  // A select rise during powerdown is ignored; the port is off then.
  assign sel_rise = s_sel && !prev_ff[PIN_SEL] && !s_pd;
  // Release of powerdown is seen once, to restore the power-on codes.
  assign pd_fall = !s_pd && prev_ff[PIN_PD];

  // Shifter, latch and serial output next values.
  // Powerdown wins over every serial event, since the port is off then.
  // Rise and fall strobes never coincide, so shift and output update apart.
  always_comb begin
    nxt_shift = shift_ff;
    nxt_latch = latch_ff;
    nxt_dout = dout_ff;
    if (s_pd || pd_fall) begin
      // Powerdown holds the port in its power-on state; release keeps it there.
      nxt_shift = SHIFT_RESET;
      nxt_latch = LATCH_RESET;
      nxt_dout = SHIFT_RESET[MSB_POS];
    end else begin
      if (clk_rise) begin
        // First bit in ends up at the MSB after eight shifts.
        nxt_shift = {shift_ff[WORD_W-2:0], s_dat};
      end
      if (clk_fall) begin
        nxt_dout = shift_ff[MSB_POS];
      end
      if (sel_rise) begin
        nxt_latch = shift_ff;
      end
    end
  end

  // Decoded channel outputs, registered so every output leaves a flop.
  // They decode the latch's next value, so codes and latch change on one edge.
  // Each channel reads only its own nibble, so the two never interact.
  always_comb begin
    nxt_ga = chan_code(nxt_latch, A_LO);
    nxt_gb = chan_code(nxt_latch, B_LO);
    nxt_ena = code_enabled(nxt_ga) && !s_pd;
    nxt_enb = code_enabled(nxt_gb) && !s_pd;
  end

  // Register stage for the port state.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      shift_ff <= SHIFT_RESET;
      latch_ff <= LATCH_RESET;
      dout_ff <= SHIFT_RESET[MSB_POS];  // Output shows the cleared shifter MSB.
    end else begin
      shift_ff <= nxt_shift;
      latch_ff <= nxt_latch;
      dout_ff <= nxt_dout;
    end
  end

  // Register stage for the channel codes and enables.
  // Reset puts both channels in software shutdown, with the amplifiers off.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ga_ff <= CODE_SW_OFF;
      gb_ff <= CODE_SW_OFF;
      ena_ff <= 1'b0;
      enb_ff <= 1'b0;
    end else begin
      ga_ff <= nxt_ga;
      gb_ff <= nxt_gb;
      ena_ff <= nxt_ena;
      enb_ff <= nxt_enb;
    end
  end

  // The serial output is a plain driven output; it never floats.
  // The cost is that it cannot share a wire with other serial outputs.
  // Every top output below is a flop, so no logic glitch reaches a pin.
  assign ser_data_o = dout_ff;
  assign gain_latch_o = latch_ff;
  assign gain_a_o = ga_ff;
  assign gain_b_o = gb_ff;
  assign amp_a_en_o = ena_ff;
  assign amp_b_en_o = enb_ff;

  // A synced rising clock shifts the data bit in next cycle.
  a_shift_in: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (clk_rise && !pd_fall) |=> shift_ff == {$past(shift_ff[WORD_W-2:0]), $past(s_dat)})
    else $error("Shift register did not take the input bit.");

  // Select rising copies the shifter into the latch.
  a_latch_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (sel_rise && !pd_fall) |=> latch_ff == $past(shift_ff))
    else $error("Latch did not load on select rising edge.");

  // Select high keeps the shifter frozen.
  a_clock_block: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (s_sel && !s_pd && !pd_fall) |=> $stable(shift_ff))
    else $error("Shifter changed while select was high.");

  // Falling clock shows the shifter MSB.
  a_dout_fall: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (clk_fall && !pd_fall) |=> ser_data_o == $past(shift_ff[MSB_POS]))
    else $error("Serial output missed the shifter MSB.");

  // A code of 8 or more on channel A always comes with channel A off.
  a_sw_off_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (gain_a_o >= CODE_SW_OFF) |-> !amp_a_en_o)
    else $error("Channel A enabled in software shutdown.");

  // Powerdown keeps both channels off.
  a_pd_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_pd |=> (!amp_a_en_o && !amp_b_en_o && latch_ff == LATCH_RESET))
    else $error("Channel enabled during hardware powerdown.");

  // Powerdown release restores the power-on code.
  a_pd_release: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    pd_fall |=> (latch_ff == LATCH_RESET) && (gain_a_o == CODE_SW_OFF) &&
      (gain_b_o == CODE_SW_OFF))
    else $error("Powerdown release did not restore code 8.");

  // Latch changes only on load or powerdown.
  a_latch_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!sel_rise && !s_pd && !pd_fall) |=> $stable(latch_ff))
    else $error("Latch changed without a load.");

  // Channel fields follow the latch nibbles on the same edge.
  a_nibble_map: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |-> (gain_b_o == latch_ff[B_LO +: CODE_W]) &&
      (gain_a_o == latch_ff[A_LO +: CODE_W]))
    else $error("Channel codes do not match latch nibbles.");

  // The checks below cover holding, loading and the two shutdown paths.
  // Each one except the reset check names the rule it guards in the comment line above its label line.

  // Without a rising clock the shifter keeps its word.
  a_shift_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!clk_rise && !s_pd && !pd_fall) |=> $stable(shift_ff))
    else $error("Shifter moved without a rising serial clock.");

  // Without a falling clock the serial output holds its level.
  a_dout_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!clk_fall && !s_pd && !pd_fall) |=> $stable(ser_data_o))
    else $error("Serial output moved without a falling serial clock.");

  // Select high also freezes the serial output.
  a_sel_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (s_sel && !s_pd && !pd_fall) |=> $stable(ser_data_o))
    else $error("Serial output moved while select was high.");

  // A load sets both channel codes from the shifter together.
  a_load_gain: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (sel_rise && !pd_fall) |=> (gain_a_o == $past(shift_ff[A_LO +: CODE_W])) &&
      (gain_b_o == $past(shift_ff[B_LO +: CODE_W])))
    else $error("Channel codes did not follow the loaded word.");

  // A loaded code below 8 runs channel A; 8 or more stops it.
  a_load_en_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (sel_rise && !pd_fall) |=> amp_a_en_o == ($past(shift_ff[A_LO +: CODE_W]) < CODE_SW_OFF))
    else $error("Channel A enable does not match the loaded code.");

  // A loaded code below 8 runs channel B; 8 or more stops it.
  a_load_en_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (sel_rise && !pd_fall) |=> amp_b_en_o == ($past(shift_ff[B_LO +: CODE_W]) < CODE_SW_OFF))
    else $error("Channel B enable does not match the loaded code.");

  // Channel B is off whenever its code is 8 or more.
  a_sw_off_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (gain_b_o >= CODE_SW_OFF) |-> !amp_b_en_o)
    else $error("Channel B enabled in software shutdown.");

  // Channel A with a code below 8 keeps running while the port is quiet.
  a_run_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!s_pd && !pd_fall && !sel_rise && (gain_a_o < CODE_SW_OFF)) |=> amp_a_en_o)
    else $error("Channel A stopped with a running code.");

  // Channel B with a code below 8 keeps running while the port is quiet.
  a_run_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!s_pd && !pd_fall && !sel_rise && (gain_b_o < CODE_SW_OFF)) |=> amp_b_en_o)
    else $error("Channel B stopped with a running code.");

  // Powerdown clears the shifter and the serial output.
  a_pd_port: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_pd |=> (shift_ff == SHIFT_RESET) && (ser_data_o == SHIFT_RESET[MSB_POS]))
    else $error("Serial port active during hardware powerdown.");

  // A select rise during powerdown loads nothing.
  a_pd_no_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (s_pd && s_sel && !prev_ff[PIN_SEL]) |=> (latch_ff == LATCH_RESET))
    else $error("Latch loaded during hardware powerdown.");

  // Release of powerdown leaves the shifter cleared and both channels off.
  a_release_port: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    pd_fall |=> (shift_ff == SHIFT_RESET) && !amp_a_en_o && !amp_b_en_o)
    else $error("Powerdown release left the port active.");

  // Reset is the trigger here, so this check has no disable condition.
  a_reset_state: assert property (@(posedge sys_clk_i)
    reset_i |=> (latch_ff == LATCH_RESET) && (gain_a_o == CODE_SW_OFF) &&
      (gain_b_o == CODE_SW_OFF) && !amp_a_en_o && !amp_b_en_o)
    else $error("Reset did not restore the power-on codes.");

  // While a frame is being shifted the latch keeps its word.
  a_low_no_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!s_sel && !s_pd && !pd_fall) |=> $stable(latch_ff))
    else $error("Latch changed while a frame was shifting.");

  // Channel codes hold between loads.
  a_hold_gain: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!sel_rise && !s_pd && !pd_fall) |=> $stable(gain_a_o) && $stable(gain_b_o))
    else $error("Channel codes changed without a load.");

  // Channel enables hold between loads as well.
  a_en_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!sel_rise && !s_pd && !pd_fall) |=> $stable(amp_a_en_o) && $stable(amp_b_en_o))
    else $error("Channel enables changed without a load.");

endmodule : gain_cfg_port

/* File: serial_host.sv */
// Purpose: Behavioural host that writes words into the three-wire serial port.
// Assumes: A 400 ns serial clock, unrelated in phase to sys_clk_i.
// Notes: The clock rests low between frames; the released data line is inverted.
`timescale 1ns/10ps
module serial_host (
  input wire logic ser_data_i,   // Daisy-chain output of the port.
  output logic select_load_n_o,  // Select/load, active low.
  output logic ser_clk_o,        // Serial clock.
  output logic ser_data_o        // Serial data.
);
  localparam time HALF = 200;  // Half of the 400 ns serial period.

  // All lines idle from time zero so the port sees no stray edge.
  initial begin
    select_load_n_o = 1'b1;
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
  end

  // Sends one word and returns what fell out of the chain output meanwhile.
  task automatic send(input logic [7:0] word, output logic [7:0] seen);
    ser_clk_o = 1'b0;  // Clock is low before select falls
    #HALF select_load_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      ser_data_o = word[i];  // Most significant bit goes first
      #HALF ser_clk_o = 1'b1;
      #(HALF - 50) seen[i] = ser_data_i;
      #50 ser_clk_o = 1'b0;
    end
    #HALF select_load_n_o = 1'b1;
    #HALF ser_data_o = ~ser_data_o;  // A released line must not keep the last bit.
  endtask : send

  // Toggles the clock with select high; the port must ignore it.
  task automatic idle_clocks(input int n);
    ser_data_o = 1'b1;
    repeat (n) begin
      #HALF ser_clk_o = 1'b1;
      #HALF ser_clk_o = 1'b0;
    end
  endtask : idle_clocks
endmodule : serial_host

/* File: dual_gain_serial_config_tb.sv */
// Purpose: Self-checking bench for the gain configuration port.
// Assumes: The serial host model drives the three serial pins.
// Notes: Rows hold {enable B, enable A, word}; odd cases follow the loop.
`timescale 1ns/10ps
module dual_gain_serial_config_tb;
  import gain_cfg_pkg::*;
  logic sys_clk = 1'b0;  // 20 MHz system clock.
  logic reset = 1'b1;  // Synchronous reset.
  logic hw_pd = 1'b0;  // Hardware powerdown.
  logic sel_n, sclk, sdin, sdout, en_a, en_b;  // Serial pins and enables.
  logic [7:0] latch, seen, prev;  // Latch, chain output, last word sent.
  logic [3:0] ga, gb;  // Channel codes.
  int err_total = 0;  // Mismatches.
  int total_checks = 0;  // Comparisons.
  int cyc = 0;  // Cycles run, for the hang limit.
  logic [9:0] rows [6] = '{10'h300, 10'h371, 10'h336, 10'h185, 10'h229, 10'h1A7};

  always #25 sys_clk = ~sys_clk;

  // The whole run needs about 950 cycles, so 5000 means a hang.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  gain_cfg_port dut (.sys_clk_i(sys_clk), .reset_i(reset), .select_load_n_i(sel_n),
    .ser_clk_i(sclk), .ser_data_i(sdin), .hw_powerdown_in_i(hw_pd), .ser_data_o(sdout),
    .gain_latch_o(latch), .gain_a_o(ga), .gain_b_o(gb), .amp_a_en_o(en_a), .amp_b_en_o(en_b));

  serial_host host (.ser_data_i(sdout), .select_load_n_o(sel_n), .ser_clk_o(sclk),
    .ser_data_o(sdin));

  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : check

  // Ten cycles cover synchroniser, latch and output stages.
  task automatic settle();
    repeat (10) @(posedge sys_clk);
    #2;
  endtask : settle

  // One frame; the chain output must replay the word sent before it.
  task automatic frame(input logic [7:0] w);
    host.send(w, seen);
    check(seen, prev);
    prev = w;
    settle();
  endtask : frame

  task automatic check_out(input logic [7:0] l, input logic [1:0] en);
    check(latch, l);
    check({gb, ga}, l);
    check({6'h00, en_b, en_a}, {6'h00, en});
  endtask : check_out

  task finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (3) @(posedge sys_clk);
    #2 reset = 1'b0;
    check_out(LATCH_RESET, 2'b00);
    check({7'h00, sdout}, 8'h00);
    prev = SHIFT_RESET;
    foreach (rows[i]) begin
      frame(rows[i][7:0]);
      check_out(rows[i][7:0], rows[i][9:8]);
    end
    // Clocks with select high must neither shift, move the output, nor load.
    host.idle_clocks(8);
    settle();
    check_out(8'hA7, 2'b01);
    frame(8'h42);
    check_out(8'h42, 2'b11);
    // Powerdown forces shutdown codes and the port ignores a whole frame.
    @(posedge sys_clk);
    #2 hw_pd = 1'b1;
    host.send(8'h11, seen);
    check(seen, SHIFT_RESET);
    settle();
    check_out(LATCH_RESET, 2'b00);
    @(posedge sys_clk);
    #2 hw_pd = 1'b0;
    settle();
    check_out(LATCH_RESET, 2'b00);
    prev = SHIFT_RESET;
    frame(8'h63);
    check_out(8'h63, 2'b11);
    // A second reset in mid-run must clear the shifter and restore the codes.
    @(posedge sys_clk);
    #2 reset = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2 reset = 1'b0;
    check_out(LATCH_RESET, 2'b00);
    check({7'h00, sdout}, 8'h00);
    prev = SHIFT_RESET;
    frame(8'h95);
    check_out(8'h95, 2'b01);
    finish_test();
  end
endmodule : dual_gain_serial_config_tb
